// ==== logic/pls_lane_steer.sv ====
// byte-lane steering and address adjustment between processor bus and pci
// assumes requests and acks arrive from logic on ref_clk_i; only reset is asynchronous
`timescale 1ns/100ps
`include "pls_map.svh"

module pls_lane_steer (
  // clock and reset
  input  wire logic              ref_clk_i,                    // 200 MHz
  input  wire logic              rst_n_i,                      // asynchronous, active low
  // requests from pci-side masters and dma
  input  wire logic              req_valid_i,                  // request present
  input  pls_pkg::pls_req_s      req_i,                        // request contents
  output logic                   req_ready_o,                  // request taken when high
  // processor-side initiator beats
  output logic                   proc_valid_o,                 // beat on the bus
  output pls_pkg::pls_beat_s     proc_beat_o,                  // beat contents
  input  wire logic              proc_ack_i,                   // beat completed
  // processor-side target alignment check
  input  wire logic              slv_start_i,                  // transfer start, one cycle
  input  wire logic [2:0]        slv_size_code_i,              // size code, 0 means eight
  input  wire logic [2:0]        slv_addr_i,                   // low address bits
  input  pls_pkg::pls_endian_e   slv_mode_i,                   // mode of the hit image
  output logic                   proc_transfer_error_ack_n_o   // error ack, active low pulse
);

  // reset release synchroniser
  logic rst_meta;  // first stage, read only by the second
  logic rst_n;     // released reset used everywhere

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // munging modes: both munging selectors behave alike here, dma picks the flavour
  function automatic logic is_munge(input pls_pkg::pls_endian_e m);
    return (m == pls_pkg::PLS_END_PPC_LE) || (m == pls_pkg::PLS_END_PPC_LE_P1);
  endfunction

  // natural alignment of a transfer
  function automatic logic is_aligned(input logic [2:0] a, input logic [3:0] sz);
    case (sz)
      `PLS_SZ_BYTE:   is_aligned = 1'b1;
      `PLS_SZ_HALF:   is_aligned = (a[0] == 1'b0);
      `PLS_SZ_WORD:   is_aligned = (a[1:0] == 2'b00);
      `PLS_SZ_DOUBLE: is_aligned = (a == `PLS_ADDR_ZERO);
      default:        is_aligned = 1'b0;
    endcase
  endfunction

  // processor lanes covered; lane 0 is the lowest address
  function automatic logic [`PLS_LANES-1:0] lane_mask(input logic [2:0] a, input logic [3:0] sz);
    logic [8:0]  ones;
    logic [15:0] sh;
    ones = 9'((9'h001 << sz) - 9'h001);
    sh   = 16'(16'(ones) << a);
    return sh[`PLS_LANES-1:0];
  endfunction

  // lane enables as the mirror presents them on the other side
  function automatic logic [`PLS_LANES-1:0] mirror_lanes(input logic [`PLS_LANES-1:0] m);
    for (int k = 0; k < `PLS_LANES; k++) begin
      mirror_lanes[k] = m[`PLS_LANES-1-k];
    end
  endfunction

  // bytes to size code: eight wraps to zero
  function automatic logic [2:0] size_code(input logic [3:0] sz);
    return sz[2:0];
  endfunction

  // target-side error: sizes the munging mode cannot carry
  function automatic logic tea_case(input logic [2:0] code, input logic [2:0] a);
    logic [3:0] sz;
    sz = (code == `PLS_CODE_DOUBLE) ? `PLS_SZ_DOUBLE : {1'b0, code};
    return (sz == `PLS_SZ_TRI) || (sz == `PLS_SZ_FIVE) || (sz == `PLS_SZ_SIX) ||
           (sz == `PLS_SZ_SEVEN) || ((sz == `PLS_SZ_HALF) && a[0]);
  endfunction

  // initiator state
  pls_pkg::pls_state_e state, next_state;  // sequencing
  pls_pkg::pls_req_s   req, next_req;      // request held for all its beats
  logic                split, next_split;  // request goes out byte by byte
  logic [3:0]          idx, next_idx;      // byte cursor while splitting
  pls_pkg::pls_beat_s  beat, next_beat;    // registered bus beat
  logic [2:0]          raw_addr, next_raw_addr;  // unmunged address of the beat

  // beat building
  logic [2:0]             cur_addr;   // address of the beat being built
  logic [3:0]             cur_size;   // bytes in that beat
  logic [`PLS_LANES-1:0]  cur_lanes;  // processor lanes used
  logic [`PLS_DATA_W-1:0] map_data;   // pci data moved onto processor lanes
  logic [`PLS_LANES-1:0]  map_mask;   // processor lanes moved onto pci lanes
  logic [2:0]             munge;      // xor pattern for the address
  logic                   swap;       // lane mirror in effect

  // one lane crossbar serves both directions since the mirror is its own inverse
  pls_lane_map #(.LANES(`PLS_LANES)) u_map (
    .swap_i (swap),
    .data_i (req.data),
    .mask_i (cur_lanes),
    .data_o (map_data),
    .mask_o (map_mask)
  );

  // address, size and munge of the beat that is about to go out
  always_comb begin
    cur_addr  = split ? 3'(req.addr + idx[2:0]) : req.addr;
    cur_size  = split ? `PLS_SZ_BYTE : req.size;
    cur_lanes = lane_mask(cur_addr, cur_size);
    // msb sits at the low processor address and the high pci lane
    swap      = (req.mode != pls_pkg::PLS_END_BIG);
    munge     = `PLS_MUNGE_NONE;
    if (is_munge(req.mode) && !req.burst) begin
      case (cur_size)
        `PLS_SZ_BYTE: munge = `PLS_MUNGE_BYTE;
        `PLS_SZ_HALF: munge = `PLS_MUNGE_HALF;
        `PLS_SZ_WORD: munge = `PLS_MUNGE_WORD;
        default:      munge = `PLS_MUNGE_NONE;       // doublewords stay put
      endcase
    end
  end

  // next-state logic of the initiator
  always_comb begin
    next_state    = state;
    next_req      = req;
    next_split    = split;
    next_idx      = idx;
    next_beat     = beat;
    next_raw_addr = raw_addr;
    case (state)
      pls_pkg::PLS_IDLE: begin
        if (req_valid_i) begin
          // mode travels with each request, so it may differ every time
          next_req   = req_i;
          next_split = is_munge(req_i.mode) && !is_aligned(req_i.addr, req_i.size);
          next_idx   = `PLS_IDX_ZERO;
          next_state = pls_pkg::PLS_LOAD;
        end
      end
      pls_pkg::PLS_LOAD: begin
        next_beat.proc_address_bus        = cur_addr ^ munge;
        next_beat.proc_transfer_size_code = size_code(cur_size);
        next_beat.data                    = map_data;
        next_beat.proc_lane_en            = cur_lanes;
        next_beat.pci_byte_en             = map_mask;
        next_raw_addr                     = cur_addr;
        next_state                        = pls_pkg::PLS_WAIT;
      end
      pls_pkg::PLS_WAIT: begin
        if (proc_ack_i) begin
          // a split request walks its bytes in address order
          if (split && ((idx + `PLS_IDX_STEP) < req.size)) begin
            next_idx   = idx + `PLS_IDX_STEP;
            next_state = pls_pkg::PLS_LOAD;
          end else begin
            next_state = pls_pkg::PLS_IDLE;
          end
        end
      end
      default: next_state = pls_pkg::PLS_IDLE;
    endcase
  end

  // initiator registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state    <= pls_pkg::PLS_IDLE;
      req      <= '0;
      split    <= 1'b0;
      idx      <= `PLS_IDX_ZERO;
      beat     <= '0;
      raw_addr <= `PLS_ADDR_ZERO;
    end else begin
      state    <= next_state;
      req      <= next_req;
      split    <= next_split;
      idx      <= next_idx;
      beat     <= next_beat;
      raw_addr <= next_raw_addr;
    end
  end

  // handshakes straight from the state; data from the beat register
  assign req_ready_o  = (state == pls_pkg::PLS_IDLE);
  assign proc_valid_o = (state == pls_pkg::PLS_WAIT);
  assign proc_beat_o  = beat;

  // target-side error acknowledge, one cycle after the start
  logic tea_n, next_tea_n;  // registered, active low

  always_comb begin
    next_tea_n = !(slv_start_i && is_munge(slv_mode_i) && tea_case(slv_size_code_i, slv_addr_i));
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tea_n <= 1'b1;
    end else begin
      tea_n <= next_tea_n;
    end
  end

  assign proc_transfer_error_ack_n_o = tea_n;

  // checks on the steering
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  // misaligned munging request taken, then its first beat is one byte
  sequence s_misaligned_take;
    (state == pls_pkg::PLS_IDLE) && req_valid_i && is_munge(req_i.mode) && !is_aligned(req_i.addr, req_i.size);
  endsequence
  sequence s_byte_beat;
    proc_valid_o && (beat.proc_transfer_size_code == `PLS_CODE_BYTE);
  endsequence

  a_split_to_bytes: assert property (s_misaligned_take |-> ##2 s_byte_beat)
    else $error("misaligned request not split into bytes");

  a_tea_bad_size: assert property (
    slv_start_i && is_munge(slv_mode_i) && ((slv_size_code_i == 3'h3) || (slv_size_code_i == 3'h5) ||
    (slv_size_code_i == 3'h6) || (slv_size_code_i == 3'h7)) |=> !proc_transfer_error_ack_n_o)
    else $error("no error ack for odd size");

  a_tea_odd_half: assert property (
    slv_start_i && is_munge(slv_mode_i) && (slv_size_code_i == 3'h2) && slv_addr_i[0]
    |=> !proc_transfer_error_ack_n_o)
    else $error("no error ack for odd halfword");

  a_tea_has_cause: assert property (
    !proc_transfer_error_ack_n_o |-> $past(slv_start_i) && is_munge($past(slv_mode_i)))
    else $error("error ack without a munging start");

  a_swap_enables: assert property (
    proc_valid_o && (req.mode != pls_pkg::PLS_END_BIG) |-> beat.pci_byte_en == mirror_lanes(beat.proc_lane_en))
    else $error("swapped enables do not mirror lanes");

  a_straight_enables: assert property (
    proc_valid_o && (req.mode == pls_pkg::PLS_END_BIG) |-> beat.pci_byte_en == beat.proc_lane_en)
    else $error("big-endian enables moved");

  a_swap_low_lane: assert property (
    proc_valid_o && (req.mode != pls_pkg::PLS_END_BIG) |-> beat.data[7:0] == req.data[63:56])
    else $error("lane zero not fed from pci lane seven");

  a_munge_byte: assert property (
    proc_valid_o && is_munge(req.mode) && !req.burst && (beat.proc_transfer_size_code == `PLS_CODE_BYTE)
    |-> beat.proc_address_bus == (raw_addr ^ `PLS_MUNGE_BYTE))
    else $error("byte address not munged");

  a_no_munge_burst: assert property (
    proc_valid_o && req.burst |-> beat.proc_address_bus == raw_addr)
    else $error("burst address munged");

  a_le_plain_addr: assert property (
    proc_valid_o && (req.mode == pls_pkg::PLS_END_LITTLE) |-> beat.proc_address_bus == raw_addr)
    else $error("little-endian address changed");

  a_munge_aligned: assert property (
    proc_valid_o && is_munge(req.mode) |-> is_aligned(raw_addr, split ? `PLS_SZ_BYTE : req.size))
    else $error("misaligned beat in munging mode");

endmodule

// ==== shared/pls_map.svh ====
// named constants for the processor-bus / PCI byte-lane steering block
// assumes an eight-lane (64-bit) processor bus and PCI data path
`ifndef PLS_MAP_SVH
`define PLS_MAP_SVH

`define PLS_LANES        8        // byte lanes on each side
`define PLS_BYTE_W       8        // bits per lane
`define PLS_DATA_W       64       // lanes times byte width

// transfer sizes in bytes
`define PLS_SZ_BYTE      4'h1
`define PLS_SZ_HALF      4'h2
`define PLS_SZ_TRI       4'h3
`define PLS_SZ_WORD      4'h4
`define PLS_SZ_FIVE      4'h5
`define PLS_SZ_SIX       4'h6
`define PLS_SZ_SEVEN     4'h7
`define PLS_SZ_DOUBLE    4'h8

// size code on the processor bus: 1..7 bytes as is, 0 means eight
`define PLS_CODE_DOUBLE  3'h0
`define PLS_CODE_BYTE    3'h1

// low address munge patterns
`define PLS_MUNGE_BYTE   3'h7
`define PLS_MUNGE_HALF   3'h6
`define PLS_MUNGE_WORD   3'h4
`define PLS_MUNGE_NONE   3'h0

`define PLS_ADDR_ZERO    3'h0
`define PLS_ADDR_STEP    3'h1
`define PLS_IDX_ZERO     4'h0
`define PLS_IDX_STEP     4'h1

`endif

// ==== shared/pls_pkg.sv ====
// types shared by the lane steering block
// assumes pls_map.svh is on the include path
`include "pls_map.svh"

package pls_pkg;

  // endian selector as carried with each request
  typedef enum logic [1:0] {
    PLS_END_BIG       = 2'b00,  // address invariant
    PLS_END_PPC_LE    = 2'b01,  // lane swap plus address munge
    PLS_END_LITTLE    = 2'b10,  // lane swap, no address change
    PLS_END_PPC_LE_P1 = 2'b11   // munging flavour for dma to the first pci bus
  } pls_endian_e;

  // initiator state machine
  typedef enum logic [1:0] {
    PLS_IDLE = 2'b00,  // waiting for a request
    PLS_LOAD = 2'b01,  // building the next beat
    PLS_WAIT = 2'b10   // beat on the bus, waiting for ack
  } pls_state_e;

  // request from a pci-side master or dma channel
  typedef struct packed {
    logic [2:0]             addr;   // start address, low three bits
    logic [3:0]             size;   // bytes, 1..8
    pls_endian_e            mode;   // endian selector
    logic                   burst;  // burst or extended cycle
    logic [`PLS_DATA_W-1:0] data;   // data on pci lanes
  } pls_req_s;

  // one processor-bus beat
  typedef struct packed {
    logic [2:0]             proc_address_bus;        // possibly munged low address
    logic [2:0]             proc_transfer_size_code; // 0 means eight bytes
    logic [`PLS_DATA_W-1:0] data;                    // data on processor lanes
    logic [`PLS_LANES-1:0]  proc_lane_en;            // processor lanes in use
    logic [`PLS_LANES-1:0]  pci_byte_en;             // matching pci lanes
  } pls_beat_s;

endpackage

// ==== logic/pls_lane_map.sv ====
// byte-lane crossbar between processor lanes and pci lanes
// assumes lane k of a bus is bits [8k+7:8k]; the swap is its own inverse
`timescale 1ns/100ps
`include "pls_map.svh"

module pls_lane_map #(
  parameter int LANES = `PLS_LANES
) (
  // control
  input  wire logic                            swap_i,  // mirror lanes k and lanes-1-k
  // data and enables in
  input  wire logic [LANES*`PLS_BYTE_W-1:0]    data_i,  // data, one side
  input  wire logic [LANES-1:0]                mask_i,  // lane enables, other side
  // mapped out
  output logic      [LANES*`PLS_BYTE_W-1:0]    data_o,  // data, steered
  output logic      [LANES-1:0]                mask_o   // enables, steered
);

  // one lane per iteration; a swap keeps significance, a straight copy keeps address
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    assign data_o[k*`PLS_BYTE_W +: `PLS_BYTE_W] =
      swap_i ? data_i[(LANES-1-k)*`PLS_BYTE_W +: `PLS_BYTE_W]
             : data_i[k*`PLS_BYTE_W +: `PLS_BYTE_W];
    assign mask_o[k] = swap_i ? mask_i[LANES-1-k] : mask_i[k];
  end

endmodule

// ==== testbench/pls_proc_target.sv ====
// processor-bus target model: acknowledges each beat after a set wait and keeps every beat it took
// assumes beats come from the steering block on the same clock and hold until acknowledged
`timescale 1ns/100ps

module pls_proc_target (
  // clock and reset
  input  wire logic              clk_i,    // bench clock
  input  wire logic              rst_n_i,  // active low
  // beat from the block
  input  wire logic              valid_i,  // beat on the bus
  input  pls_pkg::pls_beat_s     beat_i,   // beat contents
  input  wire logic [3:0]        wait_i,   // idle cycles before the ack
  output logic                   ack_o     // one-cycle acknowledge
);
  pls_pkg::pls_beat_s seen[$];  // beats in the order they completed
  logic [3:0]         cnt;      // wait cycles counted so far

  // ack after wait_i cycles; the beat is taken at the edge that sees ack high
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt   <= 4'h0;
    end else if (ack_o && valid_i) begin
      seen.push_back(beat_i);  // release ack at once so no second beat is acked blind
      ack_o <= #1 1'b0;
      cnt   <= 4'h0;
    end else if (valid_i) begin
      if (cnt >= wait_i) begin
        ack_o <= #1 1'b1;  // slow or prompt as the bench asks
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the lane steering block
// assumes the processor target model answers every beat; inputs move 1 ns after the rising edge
`timescale 1ns/100ps

module testbench;
  logic               ref_clk_i;       // 200 MHz
  logic               rst_n_i;         // active low
  logic               req_valid_i;     // request present
  pls_pkg::pls_req_s  req_i;           // request contents
  logic               req_ready_o;     // block idle
  logic               proc_valid_o;    // beat valid
  pls_pkg::pls_beat_s proc_beat_o;     // beat contents
  logic               proc_ack_i;      // from the target model
  logic               slv_start_i;     // target start pulse
  logic [2:0]         slv_size_code_i; // target size code
  logic [2:0]         slv_addr_i;      // target low address
  pls_pkg::pls_endian_e slv_mode_i;    // target image mode
  logic               proc_transfer_error_ack_n_o; // error ack
  logic [3:0]         ack_wait;        // target model delay
  int                 mismatches;      // failed compares
  int                 compares;        // all compares
  logic [63:0]        pat;             // request data pattern

  pls_lane_steer pls_lane_steer_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .proc_valid_o(proc_valid_o), .proc_beat_o(proc_beat_o),
    .proc_ack_i(proc_ack_i), .slv_start_i(slv_start_i), .slv_size_code_i(slv_size_code_i),
    .slv_addr_i(slv_addr_i), .slv_mode_i(slv_mode_i),
    .proc_transfer_error_ack_n_o(proc_transfer_error_ack_n_o)
  );

  pls_proc_target pls_proc_target_inst (
    .clk_i(ref_clk_i), .rst_n_i(rst_n_i), .valid_i(proc_valid_o), .beat_i(proc_beat_o),
    .wait_i(ack_wait), .ack_o(proc_ack_i)
  );

  // clock, 5 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // verdict in one place
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one comparison
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // byte order reversed across the eight lanes
  function automatic logic [63:0] mirror(input logic [63:0] d);
    for (int k = 0; k < 8; k++) mirror[8*k+:8] = d[8*(7-k)+:8];
  endfunction

  // lanes covered by a transfer, cut at lane 7
  function automatic logic [7:0] lanes(input logic [2:0] a, input logic [3:0] sz);
    logic [15:0] m;
    m = ((16'h0001 << sz) - 16'h0001) << a;
    return m[7:0];
  endfunction

  // one request, then wait for all its beats and for ready again
  task automatic xfer(input logic [2:0] a, input logic [3:0] sz, input pls_pkg::pls_endian_e md,
                      input logic bu, input int nb);
    int n;
    req_i = '{addr: a, size: sz, mode: md, burst: bu, data: pat};
    req_valid_i = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 50);
    #1 req_valid_i = 1'b0;
    check(req_ready_o, 1'b0);
    @(posedge ref_clk_i);
    #1;
    n++;
    check(proc_valid_o, 1'b1);
    while ((pls_proc_target_inst.seen.size() < nb || req_ready_o !== 1'b1) && n < 300) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      $display("Error at %0t: request never finished", $time);
      conclude();
    end
    @(posedge ref_clk_i);
    #1;
  endtask

  // compare the oldest completed beat; lane enables only where lc is set
  task automatic beat(input logic [2:0] a, input logic [2:0] c, input logic [63:0] d,
                      input logic lc, input logic [7:0] ln, input logic [7:0] pn);
    pls_pkg::pls_beat_s b;
    if (pls_proc_target_inst.seen.size() == 0) begin
      mismatches++;
      $display("Error at %0t: beat missing", $time);
    end else begin
      b = pls_proc_target_inst.seen.pop_front();
      check(b.proc_address_bus, a);
      check(b.proc_transfer_size_code, c);
      check(b.data, d);
      if (lc) begin
        check(b.proc_lane_en, ln);
        check(b.pci_byte_en, pn);
      end
    end
  endtask

  // straight lanes and unchanged address in big-endian mode, big-endian processor bus
  task automatic sc_big();
    xfer(3'h0, 4'h8, pls_pkg::PLS_END_BIG, 1'b0, 1);
    beat(3'h0, 3'h0, pat, 1'b1, 8'hff, 8'hff);
    xfer(3'h1, 4'h2, pls_pkg::PLS_END_BIG, 1'b0, 1);
    beat(3'h1, 3'h2, pat, 1'b1, 8'h06, 8'h06);
  endtask

  // mirrored lanes, no address change in plain little-endian mode
  task automatic sc_little();
    xfer(3'h3, 4'h1, pls_pkg::PLS_END_LITTLE, 1'b0, 1);
    beat(3'h3, 3'h1, mirror(pat), 1'b1, 8'h08, 8'h10);
    xfer(3'h1, 4'h7, pls_pkg::PLS_END_LITTLE, 1'b0, 1);
    beat(3'h1, 3'h7, mirror(pat), 1'b1, 8'hfe, 8'h7f);
  endtask

  // munged low address per size; doublewords and bursts pass unmunged
  task automatic sc_munge();
    xfer(3'h2, 4'h1, pls_pkg::PLS_END_PPC_LE, 1'b0, 1);
    beat(3'h5, 3'h1, mirror(pat), 1'b0, 8'h00, 8'h00);
    xfer(3'h2, 4'h2, pls_pkg::PLS_END_PPC_LE, 1'b0, 1);
    beat(3'h4, 3'h2, mirror(pat), 1'b0, 8'h00, 8'h00);
    // address 4 reaches word offset 0 once the initiator flips bit 2
    xfer(3'h4, 4'h4, pls_pkg::PLS_END_PPC_LE_P1, 1'b0, 1);
    beat(3'h0, 3'h4, mirror(pat), 1'b0, 8'h00, 8'h00);
    xfer(3'h0, 4'h8, pls_pkg::PLS_END_PPC_LE, 1'b0, 1);
    beat(3'h0, 3'h0, mirror(pat), 1'b0, 8'h00, 8'h00);
    xfer(3'h2, 4'h1, pls_pkg::PLS_END_PPC_LE, 1'b1, 1);
    beat(3'h2, 3'h1, mirror(pat), 1'b0, 8'h00, 8'h00);
  endtask

  // misaligned requests become single-byte beats, also across the lane 7 wrap, slow target
  task automatic sc_split();
    xfer(3'h1, 4'h3, pls_pkg::PLS_END_PPC_LE_P1, 1'b0, 3);
    for (int i = 1; i < 4; i++) beat(3'(i) ^ 3'h7, 3'h1, mirror(pat), 1'b0, 8'h00, 8'h00);
    ack_wait = 4'h3;
    xfer(3'h6, 4'h4, pls_pkg::PLS_END_PPC_LE, 1'b0, 4);
    for (int i = 6; i < 10; i++) beat(3'(i) ^ 3'h7, 3'h1, mirror(pat), 1'b0, 8'h00, 8'h00);
    ack_wait = 4'h0;
  endtask

  // error ack for every mode, size code and odd/even address
  task automatic sc_target();
    logic exp;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge ref_clk_i);
        #1 slv_start_i = 1'b1;
        slv_mode_i = pls_pkg::pls_endian_e'(m);
        slv_size_code_i = 3'(c);
        slv_addr_i = {2'b01, c[3]};
        check(proc_transfer_error_ack_n_o, 1'b1);
        exp = (m[0] == 1'b1) && (c[2:0] inside {3, 5, 6, 7} || (c[2:0] == 2 && c[3]));
        @(posedge ref_clk_i);
        #1 slv_start_i = 1'b0;
        check(proc_transfer_error_ack_n_o, !exp);
      end
    end
  endtask

  // main sequence
  initial begin
    mismatches = 0;
    compares = 0;
    pat = 64'h8877_6655_4433_2211;
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    slv_start_i = 1'b0;
    slv_size_code_i = 3'h0;
    slv_addr_i = 3'h0;
    slv_mode_i = pls_pkg::PLS_END_BIG;
    ack_wait = 4'h0;
    repeat (6) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    sc_big();
    sc_little();
    sc_munge();
    sc_split();
    sc_target();
    conclude();
  end
endmodule
